// file: dft_butterfly_processor.sv
// Sample FIFO and the DFT butterfly engine with its stored-program controller
`timescale 1ns/1ps

module sample_fifo
	import dft_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_reset_n,
	// Filling side
	input  wire logic             i_wr_valid,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_wr_ready,
	// Draining side
	output logic                  o_rd_valid,
	output logic      [WIDTH-1:0] o_rd_data,
	input  wire logic             i_rd_ready
);
	localparam int PTR_W = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            wptr;
		logic [PTR_W-1:0]            rptr;
		logic [PTR_W:0]              count;
	} fifo_state_t;

	fifo_state_t s_q;
	fifo_state_t s_d;
	logic        push;
	logic        pop;

	assign o_wr_ready = (s_q.count != (PTR_W+1)'(DEPTH));
	assign o_rd_valid = (s_q.count != '0);
	assign o_rd_data  = s_q.mem[s_q.rptr];
	assign push       = i_wr_valid & o_wr_ready;
	assign pop        = o_rd_valid & i_rd_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wptr] = i_wr_data;
			s_d.wptr          = s_q.wptr + 1'b1;
		end
		if (pop) begin
			s_d.rptr = s_q.rptr + 1'b1;
		end
		// Simultaneous push and pop leaves the count alone
		case ({push, pop})
			2'b10:   s_d.count = s_q.count + 1'b1;
			2'b01:   s_d.count = s_q.count - 1'b1;
			default: s_d.count = s_q.count;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : sample_fifo

// Notes on behaviour
// - Complex words are 32 bits: real half on top, imaginary half below.
// - Scratch-pad holds sixteen complex words, enough for the fourteen needed.
// - Combiner takes two complex operands, gives two sums/differences, one mode line.
// - Straight mode: Y1 is X1 plus X2, Y2 is X1 minus X2.
// - Rotated mode: X2 multiplied by j before adding to and subtracting from X1.
// - Pass 3 is straight mode fed with the scaled rotated sum of X2.
// - Pass 4 is rotated mode fed with the scaled rotated sum of X2.
// - Scaled passes first run X2 through both sides in rotated mode.
// - First strobe loads X1; second loads X2 and advances X1 to stage two.
// - Combiner results are written back at the end of the instruction slot.
// - Hold pulse captures the combiner left output for scaling.
// - Scaling is the sum of right shifts by 1, 3, 4, 6 and 8.
// - Real then imaginary parts pass the one scaler, each product kept.
// - Path switch feeds the product instead of memory on the second strobe.
// - Shifts floor toward minus infinity; a carry correction is added.
// - Correction 0, 1, 3 or 4 by sign, evenness and multiple of eight.
// - Controller loops eighty instructions in 7.68 microseconds (24 clocks each).
// - Each instruction has twelve pulse bits and a scratch-pad address.
// - Three stage columns, storage reused after each; sequenced by program.
// - Three range gates interleave within one program loop; set by program.
// - Finished values leave through the output strobe to the weighting stage.
// - Of each ten canceller samples only the last eight are stored.
// - Canceller write strobe moves buffered samples into the scratch-pad.
// - Mode line switches the combiner from straight to rotated.
module dft_butterfly_processor
	import dft_pkg::*;
#(
	parameter instr_t PROGRAM [PROG_LEN] = '{default: '0}
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_reset_n,
	// Samples from the canceller
	input  wire logic i_in_valid,
	input  wire cplx_t i_in_data,
	output logic       o_in_ready,
	// Results to the weighting stage
	output logic       o_out_valid,
	output cplx_t      o_out_data,
	// Strobes for the neighbouring circuits
	output logic       o_mag_strobe,
	output logic       o_zvf_strobe
);

	typedef struct packed {
		logic [PC_W-1:0]             pc;
		logic [SUB_W-1:0]            sub;
		cplx_t [MEM_DEPTH-1:0]       mem;
		cplx_t                       x1_first;
		cplx_t                       x1_second;
		cplx_t                       x2;
		cplx_t                       hold;
		cplx_t                       prod;
		logic                        im_pending;
		logic [CNT_W-1:0]            in_cnt;
		cplx_t                       out_data;
		logic                        out_valid;
		logic                        mag;
		logic                        zvf;
	} state_t;

	state_t             s_q;
	state_t             s_d;
	instr_t             instr;
	logic [PULSE_W-1:0] pl;
	logic               slot_start;
	logic               slot_end;
	pair_t              comb;
	logic               in_take;
	logic               in_drop;
	logic               fifo_wr_ready;
	logic               fifo_rd_valid;
	cplx_t              fifo_rd_data;
	logic               fifo_rd_ready;

	// Signed scaling by about 0.707; four chained adders carry the correction
	function automatic logic signed [PART_W-1:0] scale_part(
		input logic signed [PART_W-1:0] x
	);
		logic signed [SCALE_W-1:0] ext;
		logic        [SCALE_W-1:0] corr;
		logic signed [SCALE_W-1:0] cy [4];
		logic signed [SCALE_W-1:0] sum_a;
		logic signed [SCALE_W-1:0] sum_b;
		logic signed [SCALE_W-1:0] sum_c;
		logic signed [SCALE_W-1:0] sum;
		ext = SCALE_W'(x);
		if (!x[PART_W-1]) begin
			corr = (x[2:0] == 3'h0) ? CORR_POS_DIV8 : CORR_POS;
		end else begin
			corr = x[0] ? CORR_NEG_ODD : CORR_NEG_EVEN;
		end
		// A correction of n is n carries of one, spread along the adder chain
		for (int k = 0; k < 4; k++) begin
			cy[k] = (corr > SCALE_W'(k)) ? 18'h00001 : 18'h00000;
		end
		// Arithmetic shifts floor, so the carries even out the sign bias
		// Carries kept signed so the shifts stay arithmetic
		sum_a = (ext >>> SH_A) + (ext >>> SH_B) + cy[0];
		sum_b = sum_a + (ext >>> SH_C) + cy[1];
		sum_c = sum_b + (ext >>> SH_D) + cy[2];
		sum   = sum_c + (ext >>> SH_E) + cy[3];
		return sum[PART_W-1:0];
	endfunction : scale_part

	// Two's complement sums and differences, bits past 16 dropped
	function automatic pair_t combine(
		input cplx_t a,
		input cplx_t b,
		input logic  rotated
	);
		pair_t r;
		if (!rotated) begin
			r.y1.re = a.re + b.re;
			r.y1.im = a.im + b.im;
			r.y2.re = a.re - b.re;
			r.y2.im = a.im - b.im;
		end else begin
			r.y1.re = a.re - b.im;
			r.y1.im = a.im + b.re;
			r.y2.re = a.re + b.im;
			r.y2.im = a.im - b.re;
		end
		return r;
	endfunction : combine

	assign instr      = PROGRAM[s_q.pc];
	assign pl         = instr.pulses;
	assign slot_start = (s_q.sub == SUB_FIRST);
	assign slot_end   = (s_q.sub == SUB_LAST);

	// Mode line picks straight or rotated combining
	assign comb = combine(s_q.x1_second, s_q.x2, pl[P_MODE]);

	// Leading two samples of each block are taken and thrown away
	assign in_drop    = (s_q.in_cnt < BLOCK_SKIP);
	assign in_take    = i_in_valid & o_in_ready;
	assign o_in_ready = in_drop | fifo_wr_ready;

	// Buffer absorbs canceller bursts between program write slots
	assign fifo_rd_ready = slot_start & pl[P_CANC_WR];

	sample_fifo #(
		.WIDTH (CPLX_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock    (i_clock),
		.i_reset_n  (i_reset_n),
		.i_wr_valid (i_in_valid & ~in_drop),
		.i_wr_data  (i_in_data),
		.o_wr_ready (fifo_wr_ready),
		.o_rd_valid (fifo_rd_valid),
		.o_rd_data  (fifo_rd_data),
		.i_rd_ready (fifo_rd_ready)
	);

	always_comb begin
		s_d           = s_q;
		s_d.out_valid = 1'b0;
		s_d.mag       = 1'b0;
		s_d.zvf       = 1'b0;

		// Sequencer: fixed slot length, continuous loop
		if (slot_end) begin
			s_d.sub = SUB_FIRST;
			s_d.pc  = (s_q.pc == PC_LAST) ? PC_FIRST : s_q.pc + 1'b1;
		end else begin
			s_d.sub = s_q.sub + 1'b1;
		end

		// Input block counter
		if (in_take) begin
			s_d.in_cnt = (s_q.in_cnt == BLOCK_LAST) ? CNT_RESET : s_q.in_cnt + 1'b1;
		end

		// Strobes act at the start of a slot
		if (slot_start) begin
			if (pl[P_FIRST_OPERAND_STROBE]) begin
				s_d.x1_first = s_q.mem[instr.addr];
			end
			if (pl[P_SECOND_OPERAND_STROBE]) begin
				// Product replaces memory data while the path switch is set
				s_d.x2        = pl[P_PATH_SW] ? s_q.prod : s_q.mem[instr.addr];
				s_d.x1_second = s_q.x1_first;
			end
			if (pl[P_HOLD]) begin
				s_d.hold = comb.y1;
			end
			if (pl[P_HALF_SEL]) begin
				s_d.prod.re    = scale_part(s_q.hold.re);
				s_d.im_pending = 1'b1;
			end
			if (pl[P_OUT]) begin
				s_d.out_data  = s_q.mem[instr.addr];
				s_d.out_valid = 1'b1;
			end
			s_d.mag = pl[P_MAG];
			s_d.zvf = pl[P_ZVF];
		end

		// Imaginary half follows one clock later through the same scaler
		if (s_q.im_pending) begin
			s_d.prod.im    = scale_part(s_q.hold.im);
			s_d.im_pending = 1'b0;
		end

		// One scratch-pad write per clock; canceller data has priority
		if (slot_start && pl[P_CANC_WR] && fifo_rd_valid) begin
			s_d.mem[instr.addr] = fifo_rd_data;
		end else if (slot_end && pl[P_STORE_L]) begin
			// Written last so the combiner has the whole slot to settle
			s_d.mem[instr.addr] = comb.y1;
		end else if (slot_end && pl[P_STORE_R]) begin
			s_d.mem[instr.addr] = comb.y2;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_out_valid  = s_q.out_valid;
	assign o_out_data   = s_q.out_data;
	assign o_mag_strobe = s_q.mag;
	assign o_zvf_strobe = s_q.zvf;

endmodule : dft_butterfly_processor

// file: dft_pkg.sv
// Shared constants and types for the eight-point DFT butterfly engine
package dft_pkg;

	// Complex word layout
	localparam int PART_W = 16;
	localparam int CPLX_W = 32;

	// Scratch-pad store
	localparam int MEM_DEPTH = 16;
	localparam int ADDR_W    = 4;

	// Stored program and instruction timing
	localparam int PROG_LEN        = 80;
	localparam int PC_W            = 7;
	localparam int CLOCK_PERIOD_PS = 4000;
	localparam int PROG_CYCLE_PS   = 7750000;
	// Longest time per instruction, rounded down to whole clocks
	localparam int INSTR_CYCLES    = PROG_CYCLE_PS / (PROG_LEN * CLOCK_PERIOD_PS);
	localparam int SUB_W           = 5;
	localparam logic [SUB_W-1:0] SUB_FIRST = 5'h00;
	localparam logic [SUB_W-1:0] SUB_LAST  = SUB_W'(INSTR_CYCLES - 1);
	localparam logic [PC_W-1:0]  PC_FIRST  = 7'h00;
	localparam logic [PC_W-1:0]  PC_LAST   = PC_W'(PROG_LEN - 1);

	// Timing pulse positions in the operand field
	localparam int PULSE_W    = 12;
	localparam int P_MAG      = 11;
	localparam int P_OUT      = 10;
	localparam int P_STORE_L  = 9;
	localparam int P_STORE_R  = 8;
	localparam int P_CANC_WR  = 7;
	localparam int P_FIRST_OPERAND_STROBE    = 6;
	localparam int P_PATH_SW  = 5;
	localparam int P_MODE     = 4;
	localparam int P_SECOND_OPERAND_STROBE    = 3;
	localparam int P_HALF_SEL = 2;
	localparam int P_HOLD     = 1;
	localparam int P_ZVF      = 0;

	// Input block framing: ten samples, the first two dropped
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] BLOCK_SKIP = 4'h2;
	localparam logic [CNT_W-1:0] BLOCK_LAST = 4'h9;
	localparam logic [CNT_W-1:0] CNT_RESET  = 4'h0;

	// Sample buffer
	localparam int FIFO_DEPTH = 16;

	// Scaler shifts and rounding corrections
	localparam int SCALE_W = 18;
	localparam int SH_A    = 1;
	localparam int SH_B    = 3;
	localparam int SH_C    = 4;
	localparam int SH_D    = 6;
	localparam int SH_E    = 8;
	localparam logic [SCALE_W-1:0] CORR_POS_DIV8 = 18'h00000;
	localparam logic [SCALE_W-1:0] CORR_POS      = 18'h00001;
	localparam logic [SCALE_W-1:0] CORR_NEG_EVEN = 18'h00003;
	localparam logic [SCALE_W-1:0] CORR_NEG_ODD  = 18'h00004;

	typedef struct packed {
		logic signed [PART_W-1:0] re;
		logic signed [PART_W-1:0] im;
	} cplx_t;

	typedef struct packed {
		cplx_t y1;
		cplx_t y2;
	} pair_t;

	typedef struct packed {
		logic [PULSE_W-1:0] pulses;
		logic [ADDR_W-1:0]  addr;
	} instr_t;

	localparam cplx_t CPLX_ZERO = 32'h00000000;

endpackage : dft_pkg

// file: dft_butterfly_processor_asserts.sv
// Port timing checks for the DFT engine
`timescale 1ns/1ps
module dft_asserts
	import dft_pkg::*;
#(
	parameter instr_t PROGRAM [PROG_LEN] = '{default: '0}
) (
	input wire logic  i_clock,
	input wire logic  i_reset_n,
	input wire logic  i_in_valid,
	input wire cplx_t i_in_data,
	input wire logic  o_in_ready,
	input wire logic  o_out_valid,
	input wire cplx_t o_out_data,
	input wire logic  o_mag_strobe,
	input wire logic  o_zvf_strobe
);
	localparam int LOOP = PROG_LEN * INSTR_CYCLES;
	logic [10:0] cnt_q;
	logic [10:0] gap_q;
	logic [3:0]  blk_q;
	logic        seen_q, out_q, mag_q, zvf_q, sub0;
	instr_t      cur;
	assign cur  = PROGRAM[cnt_q / INSTR_CYCLES];
	assign sub0 = (cnt_q % INSTR_CYCLES) == 0;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{cnt_q, gap_q, blk_q, seen_q, out_q, mag_q, zvf_q} <= '0;
		end else begin
			cnt_q  <= (cnt_q == 11'(LOOP - 1)) ? 11'h000 : cnt_q + 11'h001;
			gap_q  <= o_mag_strobe ? 11'h000 : gap_q + 11'h001;
			seen_q <= seen_q | o_mag_strobe;
			if (i_in_valid && o_in_ready)
				blk_q <= (blk_q == BLOCK_LAST) ? CNT_RESET : blk_q + 4'h1;
			out_q  <= sub0 && cur.pulses[P_OUT];
			mag_q  <= sub0 && cur.pulses[P_MAG];
			zvf_q  <= sub0 && cur.pulses[P_ZVF];
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	chk_out_slot: assert property (o_out_valid == out_q)
		else $error("Result strobe outside its slot");
	chk_mag_slot: assert property (o_mag_strobe == mag_q)
		else $error("Magnitude strobe outside its slot");
	chk_zvf_slot: assert property (o_zvf_strobe == zvf_q)
		else $error("Zero velocity strobe outside its slot");
	chk_loop_period: assert property (o_mag_strobe && seen_q |-> gap_q == 11'(LOOP - 1))
		else $error("Program loop length wrong");
	chk_data_hold: assert property (!o_out_valid |-> $stable(o_out_data))
		else $error("Result data moved without strobe");
	chk_strobe_width: assert property (o_out_valid |=> !o_out_valid [*8])
		else $error("Result strobe too long");
	chk_ready_drop: assert property (blk_q < BLOCK_SKIP |-> o_in_ready)
		else $error("Ready low in drop phase");
	chk_reset_quiet: assert property ($rose(i_reset_n) |-> o_in_ready && !o_out_valid)
		else $error("Outputs busy right after reset");
	cover property (o_out_valid && o_mag_strobe);
	cover property (i_in_valid && !o_in_ready);
	cover property (o_zvf_strobe);
endmodule : dft_asserts

bind dft_butterfly_processor dft_asserts #(.PROGRAM(PROGRAM)) u_chk (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_in_valid(i_in_valid),
	.i_in_data(i_in_data), .o_in_ready(o_in_ready), .o_out_valid(o_out_valid),
	.o_out_data(o_out_data), .o_mag_strobe(o_mag_strobe), .o_zvf_strobe(o_zvf_strobe)
);

// file: canceller_model.sv
// Canceller-side sample source for the DFT engine
`timescale 1ns/1ps
package canceller_pkg;
	import dft_pkg::*;
	function automatic cplx_t sample_of(input int k);
		return '{re: 16'(k * 32'h4D0 - 32'h2328), im: 16'(32'h7531 - k * 32'hBB9)};
	endfunction : sample_of
endpackage : canceller_pkg

module canceller_model
	import dft_pkg::*;
	import canceller_pkg::*;
#(
	parameter int N_SAMPLES = 24
) (
	input  wire logic i_clock,
	input  wire logic i_reset_n,
	input  wire logic i_ready,
	output logic      o_valid,
	output cplx_t     o_data
);
	int sent;
	int refused;
	int nxt;
	assign nxt = sent + int'(o_valid && i_ready);
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sent    <= '0;
			refused <= '0;
			o_valid <= 1'b0;
			o_data  <= '0;
		end else begin
			sent    <= nxt;
			refused <= refused + int'(o_valid && !i_ready);
			// Offer held until taken, back to back until N_SAMPLES are sent
			o_valid <= nxt < N_SAMPLES;
			// Idle lines toggle so a stale sample cannot pass as fresh
			o_data  <= (nxt < N_SAMPLES) ? sample_of(nxt) : ~o_data;
		end
	end
endmodule : canceller_model

// file: dft_butterfly_processor_bench.sv
// Self-checking bench for the DFT butterfly engine
`timescale 1ns/1ps
module dft_butterfly_processor_bench import dft_pkg::*, canceller_pkg::*;;
	// Fill two cells, straight and rotated passes, outputs, then a scaled pass
	localparam instr_t PROG [PROG_LEN] = '{2: 16'h0800, 3: 16'h0801, 4: 16'h0400,
		5: 16'h2081, 6: 16'h1002, 7: 16'h2103, 8: 16'h1104, 9: 16'hC001, 10: 16'h4012,
		11: 16'h4003, 12: 16'h4004, 13: 16'h0020, 14: 16'h0040, 15: 16'h0400,
		16: 16'h2286, 17: 16'h4006, default: 16'h0000};
	logic  i_clock;
	logic  i_reset_n;
	logic  in_valid, in_ready, out_valid, mag, zvf;
	cplx_t in_data, out_data, a_m, b_m;
	cplx_t st [$];
	int    mismatches = 0;
	int    n_compared = 0;

	dft_butterfly_processor #(.PROGRAM(PROG)) uut (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_in_valid(in_valid), .i_in_data(in_data), .o_in_ready(in_ready),
		.o_out_valid(out_valid), .o_out_data(out_data), .o_mag_strobe(mag), .o_zvf_strobe(zvf));
	canceller_model u_src (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_ready(in_ready),
		.o_valid(in_valid), .o_data(in_data));

	function automatic cplx_t mk(input logic signed [15:0] r, input logic signed [15:0] i);
		return '{re: r, im: i};
	endfunction : mk
	function automatic logic signed [15:0] k_scale(input logic signed [15:0] x);
		logic signed [17:0] w;
		logic signed [17:0] c;
		w = x;
		c = x[15] ? (x[0] ? 18'h00004 : 18'h00003) : (x[2:0] == 3'h0 ? 18'h00000 : 18'h00001);
		return 16'((w >>> 1) + (w >>> 3) + (w >>> 4) + (w >>> 6) + (w >>> 8) + c);
	endfunction : k_scale
	task automatic cmp_cplx(input string nm, input cplx_t e, input cplx_t g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_cplx
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit
	task automatic get_out(output cplx_t d, output logic m, output logic z);
		int n;
		n = 0;
		@(negedge i_clock);
		while (out_valid !== 1'b1 && n < 2100) begin
			@(negedge i_clock);
			n++;
		end
		cmp_bit("result strobe", 1'b1, out_valid);
		d = out_data;
		m = mag;
		z = zvf;
	endtask : get_out
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	task automatic test_reset();
		repeat (11) @(posedge i_clock);
		@(negedge i_clock);
		cmp_bit("ready in reset", 1'b1, in_ready);
		cmp_bit("strobe in reset", 1'b0, out_valid);
		@(posedge i_clock);
		i_reset_n <= 1'b1;
	endtask : test_reset
	task automatic test_passes();
		cplx_t d, s;
		logic  m, z;
		if (st.size() > 0) begin
			a_m = st.pop_front();
			b_m = st.pop_front();
		end else begin
			// Empty buffer writes nothing, so cell 1 keeps the last sum
			b_m = mk(a_m.re + b_m.re, a_m.im + b_m.im);
		end
		s = mk(a_m.re + b_m.re, a_m.im + b_m.im);
		get_out(d, m, z);
		cmp_cplx("straight sum", s, d);
		cmp_bit("magnitude strobe", 1'b1, m);
		get_out(d, m, z);
		cmp_cplx("straight difference", mk(a_m.re - b_m.re, a_m.im - b_m.im), d);
		cmp_bit("zero velocity strobe", 1'b1, z);
		get_out(d, m, z);
		cmp_cplx("rotated sum", mk(a_m.re - b_m.im, a_m.im + b_m.re), d);
		get_out(d, m, z);
		cmp_cplx("rotated difference", mk(a_m.re + b_m.im, a_m.im - b_m.re), d);
		get_out(d, m, z);
		cmp_cplx("scaled pass", mk(a_m.re + k_scale(s.re), a_m.im + k_scale(s.im)), d);
	endtask : test_passes
	task automatic test_scale_table();
		cmp_cplx("scale of 1 and -1", mk(16'h0001, 16'hFFFF), mk(k_scale(16'h0001), k_scale(16'hFFFF)));
		cmp_cplx("scale of 16 and -16", mk(16'h000B, 16'hFFF6), mk(k_scale(16'h0010), k_scale(16'hFFF0)));
		cmp_cplx("scale of 32 and -32", mk(16'h0016, 16'hFFEB), mk(k_scale(16'h0020), k_scale(16'hFFE0)));
		cmp_cplx("scale of 3 and 8", mk(16'h0002, 16'h0005), mk(k_scale(16'h0003), k_scale(16'h0008)));
	endtask : test_scale_table
	task automatic test_fill_refuse();
		cmp_bit("offer refused when full", 1'b1, u_src.refused > 0);
		cmp_bit("all samples taken", 1'b1, u_src.sent == 24);
		cmp_bit("ready once drained", 1'b1, in_ready);
	endtask : test_fill_refuse

	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	initial begin
		// Ten program loops plus reset, with margin
		repeat (25000) @(posedge i_clock);
		mismatches++;
		close_out();
	end
	initial begin
		i_reset_n = 1'b0;
		for (int k = 0; k < 24; k++) begin
			if (k % 10 >= 2) st.push_back(sample_of(k));
		end
		test_reset();
		test_scale_table();
		repeat (10) test_passes();
		test_fill_refuse();
		close_out();
	end
endmodule : dft_butterfly_processor_bench
